// ===== verilog/svtb_bridge.sv
// Stream to video timing bridge: pixel FIFO, output synchronizer, data formatter, AHB-Lite registers
//
// How it works
// - Field bit is captured when the start-of-frame sample is accepted.
// - When locked, generator timing goes out with pixels read from the FIFO.
// - Pixel data and timing are registered before reaching the video port.
// - All video outputs stay low until lock is reported.
// - After lock, outputs start at the next rising edge of vertical blank.
// - Pixels pass a FIFO into the video timing domain, read by the synchronizer.
// - Tready is high while the FIFO has room, low only when nearly full.
// - Each tvalid and tready cycle writes the sample into the FIFO.
// - Slave mode gates FIFO reads and pauses the generator through its enable.
// - Master mode never pauses the generator, it only gates FIFO reads.
// - First FIFO read waits for the hysteresis fill level.
// - While running, alignment is checked; any discrepancy restarts initialization, except end-of-line ones during fine alignment.
// - Slave fine alignment adds generator lag when timing leads; master does not.
// - In slave fine alignment, timing end-of-line first pauses the generator until FIFO end-of-line is read or the FIFO runs empty.
// - During fine alignment, FIFO end-of-line first postpones the next FIFO read by one location.
// - Timing end-of-line comes from the fall of the active video input.
// - FIFO drains during the slave fine-alignment end-of-line pause so the end-of-line pixel gets out.
// - Lock after the threshold count of consecutive clean frames, four by default.
// - Once locked, any flag mismatch drops lock and restarts initialization.
// - Timing start-of-frame is the first active pixel after vertical sync.
// - Master mode buffers at once, reads after timing start-of-frame and hysteresis.
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "svtb_defines.svh"
module svtb_bridge
   import svtb_pkg::*;
#(
   parameter int DATA_W = 24,
   parameter int FIFO_DEPTH = `SVTB_FIFO_DEPTH,
   parameter int HYST_LEVEL = `SVTB_HYST_LEVEL,
   parameter int ROOM_MARGIN = `SVTB_ROOM_MARGIN,
   parameter int LOCK_FRAMES = `SVTB_LOCK_FRAMES
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [DATA_W-1:0] s_axis_tdata_i,
   input wire logic s_axis_tvalid_i,
   input wire logic s_axis_tuser_i,
   input wire logic s_axis_tlast_i,
   input wire logic field_id_i,
   output logic s_axis_tready_o,
   input wire logic vid_clk_i,
   input wire logic t_act_i,
   input wire logic t_hsync_i,
   input wire logic t_vsync_i,
   input wire logic t_hblank_i,
   input wire logic t_vblank_i,
   output logic gen_ce_o,
   output logic [DATA_W-1:0] vid_data_o,
   output logic vid_act_o,
   output logic vid_hsync_o,
   output logic vid_vsync_o,
   output logic vid_hblank_o,
   output logic vid_vblank_o,
   output logic vid_field_o,
   output logic locked_o
);
   localparam int AW = $clog2(FIFO_DEPTH);
   localparam int EW = DATA_W + 3;
   localparam int FW = $clog2(LOCK_FRAMES + 1);
   localparam int NS = 6;

   if (FIFO_DEPTH < 32 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || HYST_LEVEL < 1
       || HYST_LEVEL > FIFO_DEPTH - 16 || ROOM_MARGIN < 1 || ROOM_MARGIN > 16
       || LOCK_FRAMES < 1 || DATA_W < 1) begin : g_bad_params
      $error("svtb_bridge: unsupported parameter values");
   end

   // Stream side runs on core_clk_i; the pixel clock is sampled, so the FIFO read side follows its edges
   logic [NS-1:0] sync_in;
   logic [NS-1:0] meta;
   logic [NS-1:0] synced;
   assign sync_in = {vid_clk_i, t_act_i, t_hsync_i, t_vsync_i, t_hblank_i, t_vblank_i};
   genvar gi;
   for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge core_clk_i) begin
         if (sys_rst_i) begin
            meta[gi] <= 1'b0;
            synced[gi] <= 1'b0;
         end else begin
            meta[gi] <= sync_in[gi];
            synced[gi] <= meta[gi];
         end
      end
   end

   logic t_act;
   logic t_hsync;
   logic t_vsync;
   logic t_hblank;
   logic t_vblank;
   logic vclk_d;
   logic pix;
   assign t_act = synced[4];
   assign t_hsync = synced[3];
   assign t_vsync = synced[2];
   assign t_hblank = synced[1];
   assign t_vblank = synced[0];
   assign pix = synced[5] & ~vclk_d;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         vclk_d <= 1'b0;
      end else begin
         vclk_d <= synced[5];
      end
   end

   // Timing-side flags, sampled once per pixel
   logic act_d;
   logic vblank_d;
   logic vs_seen;
   logic t_eol_now;
   logic t_sof_now;
   logic vblank_rise;
   assign t_eol_now = pix & act_d & ~t_act;
   assign t_sof_now = pix & t_act & ~act_d & vs_seen;
   assign vblank_rise = pix & t_vblank & ~vblank_d;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         act_d <= 1'b0;
         vblank_d <= 1'b0;
         vs_seen <= 1'b0;
      end else if (pix) begin
         act_d <= t_act;
         vblank_d <= t_vblank;
         if (t_vsync) begin
            vs_seen <= 1'b1;
         end else if (t_sof_now) begin
            vs_seen <= 1'b0;
         end
      end
   end

   // Pixel FIFO: entry is {field, sof, eol, data}
   logic [EW-1:0] mem [FIFO_DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] level;
   logic [EW-1:0] head;
   logic fid_cap;
   logic entry_fid;
   logic wr_en;
   logic rd_en;
   logic drop;
   logic pop;
   logic fifo_empty;
   logic head_sof;
   logic head_eol;
   assign s_axis_tready_o = level < (AW+1)'(FIFO_DEPTH - ROOM_MARGIN);
   assign wr_en = s_axis_tvalid_i & s_axis_tready_o;
   assign entry_fid = s_axis_tuser_i ? field_id_i : fid_cap;
   assign fifo_empty = level == '0;
   assign head = mem[rd_ptr];
   assign head_sof = head[DATA_W+1];
   assign head_eol = head[DATA_W];
   assign pop = (rd_en | drop) & ~fifo_empty;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         fid_cap <= 1'b0;
      end else if (wr_en && s_axis_tuser_i) begin
         fid_cap <= field_id_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (wr_en) begin
         mem[wr_ptr] <= {entry_fid, s_axis_tuser_i, s_axis_tlast_i, s_axis_tdata_i};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         if (wr_en) begin
            wr_ptr <= AW'(wr_ptr + 1'b1);
         end
         if (pop) begin
            rd_ptr <= AW'(rd_ptr + 1'b1);
         end
         level <= (AW+1)'(level + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, pop});
      end
   end

   // Registers
   logic master_mode;
   logic [15:0] lag_cnt;
   logic out_en;
   svtb_state_e state_q;
   svtb_state_e next_state;

   // Synchronizer read and check terms
   logic running;
   logic ready_fifo;
   logic start;
   logic rd_norm;
   logic rd_flush;
   logic skip;
   logic eol_pend;
   logic pause_eol;
   logic hold_sof;
   logic eol_ahead_t;
   logic eol_ahead_f;
   logic mismatch;
   logic mode_chg;
   logic [FW-1:0] frame_cnt;
   assign running = state_q inside {SVTB_FINE, SVTB_MATCHED, SVTB_LOCKED};
   assign ready_fifo = ~fifo_empty & head_sof & (level >= (AW+1)'(HYST_LEVEL));
   // Master waits for a real timing start-of-frame; slave may hold the generator there instead
   assign start = pix & (state_q == SVTB_COARSE) & (t_sof_now | hold_sof) & ready_fifo;
   assign rd_norm = pix & running & t_act & ~skip;
   assign rd_flush = pix & pause_eol;
   assign rd_en = start | rd_norm | rd_flush;
   // Flush in either mode drops samples until a frame start heads the FIFO; coarse alignment then buffers and can apply back pressure
   assign drop = (state_q == SVTB_FLUSH) & ~head_sof;
   assign eol_ahead_t = running & t_eol_now & ~eol_pend;
   assign eol_ahead_f = running & pix & eol_pend & t_act;
   assign mismatch = (rd_norm & (fifo_empty | (head_sof != t_sof_now)))
                     | (running & t_sof_now & ~rd_norm)
                     | ((state_q != SVTB_FINE) & (eol_ahead_t | eol_ahead_f));

   always_comb begin
      next_state = state_q;
      unique case (state_q)
         SVTB_FLUSH: begin
            if (~fifo_empty && head_sof) begin
               next_state = SVTB_COARSE;
            end
         end
         SVTB_COARSE: begin
            if (start) begin
               next_state = SVTB_FINE;
            end
         end
         SVTB_FINE: begin
            if (mismatch) begin
               next_state = SVTB_FLUSH;
            end else if (t_sof_now) begin
               next_state = SVTB_MATCHED;
            end
         end
         SVTB_MATCHED: begin
            if (mismatch) begin
               next_state = SVTB_FLUSH;
            end else if (t_sof_now && frame_cnt == FW'(LOCK_FRAMES - 1)) begin
               next_state = SVTB_LOCKED;
            end
         end
         SVTB_LOCKED: begin
            if (mismatch) begin
               next_state = SVTB_FLUSH;
            end
         end
      endcase
      if (mode_chg) begin
         next_state = SVTB_FLUSH;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_q <= SVTB_FLUSH;
         frame_cnt <= '0;
      end else begin
         state_q <= next_state;
         if (state_q != SVTB_MATCHED) begin
            frame_cnt <= '0;
         end else if (t_sof_now) begin
            frame_cnt <= FW'(frame_cnt + 1'b1);
         end
      end
   end

   // End-of-line bookkeeping; a read of the eol sample wins over the timing clear
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || !running) begin
         eol_pend <= 1'b0;
      end else if ((rd_norm || start) && !fifo_empty && head_eol) begin
         eol_pend <= 1'b1;
      end else if (t_eol_now) begin
         eol_pend <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || !running) begin
         skip <= 1'b0;
      end else if (state_q == SVTB_FINE && eol_ahead_f) begin
         skip <= 1'b1;
      end else if (pix && t_act) begin
         skip <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || state_q != SVTB_FINE || master_mode) begin
         pause_eol <= 1'b0;
      end else if (eol_ahead_t) begin
         pause_eol <= 1'b1;
      end else if (rd_flush && (fifo_empty || head_eol)) begin
         pause_eol <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || state_q != SVTB_COARSE || master_mode || start) begin
         hold_sof <= 1'b0;
      end else if (t_sof_now && !ready_fifo) begin
         hold_sof <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         gen_ce_o <= 1'b1;
      end else begin
         gen_ce_o <= master_mode | ~(pause_eol | hold_sof);
      end
   end

   // Lag gained by pausing the generator; useful for sizing the FIFO
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || state_q == SVTB_FLUSH) begin
         lag_cnt <= '0;
      end else if (pix && !gen_ce_o) begin
         lag_cnt <= 16'(lag_cnt + 1'b1);
      end
   end

   assign locked_o = state_q == SVTB_LOCKED;

   // Data formatter
   logic field_r;
   logic field_now;
   assign field_now = (rd_en && !fifo_empty) ? head[DATA_W+2] : field_r;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || !locked_o) begin
         out_en <= 1'b0;
      end else if (vblank_rise) begin
         out_en <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         field_r <= 1'b0;
      end else if (pix) begin
         field_r <= field_now;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         vid_data_o <= '0;
         vid_act_o <= 1'b0;
         vid_hsync_o <= 1'b0;
         vid_vsync_o <= 1'b0;
         vid_hblank_o <= 1'b0;
         vid_vblank_o <= 1'b0;
         vid_field_o <= 1'b0;
      end else if (pix) begin
         vid_data_o <= (out_en && rd_en && !fifo_empty) ? head[DATA_W-1:0] : '0;
         vid_act_o <= out_en & t_act;
         vid_hsync_o <= out_en & t_hsync;
         vid_vsync_o <= out_en & t_vsync;
         vid_hblank_o <= out_en & t_hblank;
         vid_vblank_o <= out_en & t_vblank;
         vid_field_o <= out_en & field_now;
      end
   end

   // AHB-Lite slave, zero wait states, always OKAY
   logic ap_wr;
   logic [31:0] ap_addr;
   logic ap_valid;
   logic ctrl_view;
   assign ap_valid = hsel_i & htrans_i[1] & hready_i;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign mode_chg = ap_wr & (ap_addr == `SVTB_CTRL_OFS) & (hwdata_i[`SVTB_CTRL_MASTER_BIT] != master_mode);
   // A read right behind a control write sees the new value
   assign ctrl_view = (ap_wr && ap_addr == `SVTB_CTRL_OFS) ? hwdata_i[`SVTB_CTRL_MASTER_BIT] : master_mode;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ap_wr <= 1'b0;
         ap_addr <= '0;
      end else begin
         ap_wr <= ap_valid & hwrite_i;
         ap_addr <= haddr_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         master_mode <= `SVTB_CTRL_RESET;
      end else if (ap_wr && ap_addr == `SVTB_CTRL_OFS) begin
         master_mode <= hwdata_i[`SVTB_CTRL_MASTER_BIT];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         hrdata_o <= '0;
      end else if (ap_valid && !hwrite_i) begin
         hrdata_o <= '0;
         unique case (haddr_i)
            `SVTB_CTRL_OFS: hrdata_o[`SVTB_CTRL_MASTER_BIT] <= ctrl_view;
            `SVTB_STAT_OFS: begin
               hrdata_o[`SVTB_STAT_LOCK_BIT] <= locked_o;
               hrdata_o[`SVTB_STAT_OUTEN_BIT] <= out_en;
               hrdata_o[`SVTB_STAT_STATE_LSB+:3] <= state_q;
            end
            `SVTB_LAG_OFS: hrdata_o[15:0] <= lag_cnt;
            `SVTB_LEVEL_OFS: hrdata_o[AW:0] <= level;
            default: hrdata_o <= '0;
         endcase
      end
   end

   // Checks
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   fid_capture_a: assert property (wr_en && s_axis_tuser_i |=> fid_cap == $past(field_id_i))
      else $error("field bit not captured at frame start");
   fmt_forward_a: assert property ((pix && out_en) |=> vid_act_o == $past(t_act) && vid_vblank_o == $past(t_vblank)
      && vid_vsync_o == $past(t_vsync))
      else $error("timing not forwarded through output register");
   out_low_a: assert property ((pix && !out_en) |=> vid_data_o == '0 && !vid_act_o && !vid_hsync_o
      && !vid_vsync_o && !vid_hblank_o && !vid_vblank_o && !vid_field_o)
      else $error("video output active while disabled");
   out_start_a: assert property ($rose(out_en) |-> $past(locked_o && vblank_rise))
      else $error("output enabled away from vertical blank edge");
   write_store_a: assert property ((wr_en && !pop) |=> level == $past(level) + 1'b1)
      else $error("accepted sample not stored");
   room_ready_a: assert property ((level < (AW+1)'(FIFO_DEPTH - ROOM_MARGIN)) |-> s_axis_tready_o)
      else $error("tready low with room in FIFO");
   master_no_pause_a: assert property (master_mode |=> gen_ce_o)
      else $error("generator paused in master mode");
   eol_pause_a: assert property ($rose(pause_eol) |=> !gen_ce_o)
      else $error("generator not paused for late FIFO end of line");
   skip_one_a: assert property ((state_q == SVTB_FINE && eol_ahead_f && !mismatch) |=> skip ##0 !rd_norm)
      else $error("read not postponed after early FIFO end of line");
   hyst_start_a: assert property ((state_q == SVTB_COARSE && rd_en) |-> level >= (AW+1)'(HYST_LEVEL))
      else $error("first read below hysteresis level");
   master_sof_a: assert property ((master_mode && state_q == SVTB_COARSE && rd_en) |-> t_sof_now)
      else $error("master read started off timing frame start");
   lock_count_a: assert property ($rose(locked_o) |-> $past(frame_cnt) == FW'(LOCK_FRAMES - 1))
      else $error("lock declared after wrong frame count");
   drop_lock_a: assert property ((locked_o && mismatch) |=> state_q == SVTB_FLUSH && !locked_o)
      else $error("lock kept after mismatch");
endmodule
`default_nettype wire

// ===== verilog/svtb_defines.svh
// Register offsets, field positions, reset values and default counts of the stream to video bridge
`ifndef SVTB_DEFINES_SVH
`define SVTB_DEFINES_SVH
`define SVTB_CTRL_OFS 32'h0000_0000
`define SVTB_STAT_OFS 32'h0000_0004
`define SVTB_LAG_OFS 32'h0000_0008
`define SVTB_LEVEL_OFS 32'h0000_000C
`define SVTB_CTRL_MASTER_BIT 0
`define SVTB_CTRL_RESET 1'b0
`define SVTB_STAT_LOCK_BIT 0
`define SVTB_STAT_OUTEN_BIT 1
`define SVTB_STAT_STATE_LSB 4
`define SVTB_FIFO_DEPTH 32
`define SVTB_HYST_LEVEL 12
`define SVTB_ROOM_MARGIN 2
`define SVTB_LOCK_FRAMES 4
`endif

// ===== verilog/svtb_pkg.sv
// Types shared by the stream to video bridge
package svtb_pkg;
   typedef enum logic [2:0] {
      SVTB_FLUSH,
      SVTB_COARSE,
      SVTB_FINE,
      SVTB_MATCHED,
      SVTB_LOCKED
   } svtb_state_e;
endpackage

// ===== tb/svtb_far_end.sv
// Far-side model: upstream stream source and gated video timing generator
`timescale 1ns/100ps
`default_nettype none
module svtb_far_end #(
   parameter int W = 20,
   parameter int H = 4
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic vid_clk_i,
   input wire logic gen_ce_i,
   input wire logic tready_i,
   input wire logic short_i,
   input wire logic hold_i,
   output logic [23:0] tdata_o,
   output logic tvalid_o,
   output logic tuser_o,
   output logic tlast_o,
   output logic field_o,
   output logic t_act_o,
   output logic t_hsync_o,
   output logic t_vsync_o,
   output logic t_hblank_o,
   output logic t_vblank_o
);
   int hc = 0;
   int vc = 0;
   int p;
   int l;
   int f;
   int len;
   // Generator free-runs from time zero; it only stands while the bridge holds its enable
   always @(posedge vid_clk_i) begin
      if (gen_ce_i) begin
         hc <= (hc == W + 7) ? 0 : hc + 1;
         if (hc == W + 7) begin
            vc <= (vc == H + 1) ? 0 : vc + 1;
         end
      end
   end
   assign t_act_o = (hc < W) && (vc < H);
   assign t_hblank_o = hc >= W;
   assign t_hsync_o = (hc >= W + 2) && (hc < W + 5);
   assign t_vblank_o = vc >= H;
   assign t_vsync_o = vc == H + 1;
   // Source runs ahead of the pixel rate, so back pressure paces it
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         tvalid_o <= 1'b0;
         tdata_o <= 24'h00_0000;
         tuser_o <= 1'b0;
         tlast_o <= 1'b0;
         field_o <= 1'b0;
         p = 0;
         l = 0;
         f = 0;
         len = W;
      end else if (!tvalid_o || tready_i) begin
         if (tvalid_o) begin
            p = p + 1;
            if (p == len) begin
               p = 0;
               l = (l == H - 1) ? 0 : l + 1;
               f = (l == 0) ? f + 1 : f;
            end
         end
         if (p == 0) begin
            len = short_i ? W - 1 : W;
         end
         // Hold only takes effect once the current beat is accepted, so the stream rules are kept
         if (hold_i || $urandom_range(3) == 0) begin
            // Released lines toggle so a stale sample never looks valid
            tvalid_o <= 1'b0;
            tdata_o <= ~tdata_o;
            tuser_o <= ~tuser_o;
            tlast_o <= ~tlast_o;
         end else begin
            tvalid_o <= 1'b1;
            tdata_o <= {f[7:0], l[7:0], p[7:0]};
            tuser_o <= (p == 0) && (l == 0);
            tlast_o <= p == len - 1;
            if (p == 0 && l == 0) begin
               field_o <= f[0];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/stream_to_video_timing_bridge_tb.sv
// Self-checking bench of the stream to video timing bridge
`timescale 1ns/100ps
`default_nettype none
`include "svtb_defines.svh"
module stream_to_video_timing_bridge_tb;
   logic core_clk = 1'b0;
   logic vid_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [23:0] tdata;
   logic tvalid, tuser, tlast, field, tready;
   logic t_act, t_hsync, t_vsync, t_hblank, t_vblank, gen_ce;
   logic [23:0] vd;
   logic va, vh, vv, vhb, vvb, vf, locked;
   logic short_req = 1'b0;
   logic hold = 1'b1;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   int gp = 0;
   int gl = 0;
   int ce_low = 0;
   int px_seen = 0;
   int tr_low = 0;
   bit en = 0;
   bit vb_prev = 0;
   bit run_chk = 0;
   bit master_chk = 0;
   logic [31:0] rd;
   logic tr;

   svtb_bridge #(.LOCK_FRAMES(1)) dut (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
      .s_axis_tdata_i(tdata), .s_axis_tvalid_i(tvalid), .s_axis_tuser_i(tuser), .s_axis_tlast_i(tlast),
      .field_id_i(field), .s_axis_tready_o(tready), .vid_clk_i(vid_clk), .t_act_i(t_act),
      .t_hsync_i(t_hsync), .t_vsync_i(t_vsync), .t_hblank_i(t_hblank), .t_vblank_i(t_vblank),
      .gen_ce_o(gen_ce), .vid_data_o(vd), .vid_act_o(va), .vid_hsync_o(vh), .vid_vsync_o(vv),
      .vid_hblank_o(vhb), .vid_vblank_o(vvb), .vid_field_o(vf), .locked_o(locked));

   svtb_far_end far (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .vid_clk_i(vid_clk), .gen_ce_i(gen_ce),
      .tready_i(tready), .short_i(short_req), .hold_i(hold), .tdata_o(tdata), .tvalid_o(tvalid), .tuser_o(tuser),
      .tlast_o(tlast), .field_o(field), .t_act_o(t_act), .t_hsync_o(t_hsync), .t_vsync_o(t_vsync),
      .t_hblank_o(t_hblank), .t_vblank_o(t_vblank));

   always #2 core_clk = ~core_clk;
   initial begin
      #7;
      forever #16 vid_clk = ~vid_clk;
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 100000) begin
         fails++;
         $display("CHECK FAILED run length expected below 100000 seen %0d", cyc);
         tally_and_finish();
      end
   end

   // One word per call; tready is caught at the edge that loads the read data
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      tr = tready;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wait_lock(input logic v, input int lim, input string nm);
      int i;
      for (i = 0; i < lim && locked !== v; i++) @(posedge core_clk);
      check(nm, locked, v);
   endtask

   task automatic wait_frames(input int n);
      repeat (n) @(posedge t_vsync);
      @(posedge core_clk);
   endtask

   // Model of the video side, sampled late in each pixel when outputs have settled
   always @(posedge vid_clk) begin
      #30;
      if (gen_ce === 1'b0) ce_low++;
      if (run_chk) begin
         check("act", va, en & t_act);
         check("hsync", vh, en & t_hsync);
         check("vsync", vv, en & t_vsync);
         check("hblank", vhb, en & t_hblank);
         check("vblank", vvb, en & t_vblank);
         if (master_chk) check("gen enable", gen_ce, 1);
         if (en && t_act) begin
            px_seen++;
            check("pixel", vd[15:0], {gl[7:0], gp[7:0]});
            check("field", vf, vd[16]);
         end
      end
      if (t_act) gp++;
      else if (gp != 0) begin
         gp = 0;
         gl++;
      end
      if (t_vsync) gl = 0;
      // The enable registered at this pixel only shows on the next one
      if (locked !== 1'b1) en = 0;
      else if (t_vblank && !vb_prev) en = 1;
      vb_prev = t_vblank;
   end

   initial begin
      void'($urandom(32'h3b07));
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      check("tready idle", tready, 1);
      check("gen enable idle", gen_ce, 1);
      check("lock idle", locked, 0);
      ahb(0, `SVTB_CTRL_OFS, 0);
      check("ctrl reset", rd, 0);
      ahb(1, 32'h0000_0010, 32'hffff_ffff);
      ahb(0, 32'h0000_0010, 0);
      check("unmapped", rd, 0);
      check("hresp", hresp, 0);
      // Let a frame start head the FIFO, then starve it past the timing frame start so the generator is held
      @(posedge t_vsync);
      @(posedge core_clk);
      hold <= 1'b0;
      do @(posedge core_clk); while (!(tvalid === 1'b1 && tready === 1'b1));
      hold <= 1'b1;
      @(negedge t_vsync);
      repeat (8) @(posedge core_clk);
      hold <= 1'b0;
      run_chk = 1;
      wait_lock(1, 60000, "slave lock");
      ahb(0, `SVTB_STAT_OFS, 0);
      check("status lock", rd[`SVTB_STAT_LOCK_BIT], 1);
      ahb(0, `SVTB_LAG_OFS, 0);
      check("lag grown", rd[15:0] != 16'h0000, 1);
      check("gen paused", ce_low > 0, 1);
      wait_frames(3);
      check("slave pixels", px_seen > 0, 1);
      // Mode change restarts the synchronizer; boundary pixels are not judged
      run_chk = 0;
      ahb(1, `SVTB_CTRL_OFS, 32'h0000_0001);
      ahb(0, `SVTB_CTRL_OFS, 0);
      check("ctrl master", rd, 1);
      wait_lock(0, 400, "restart on mode");
      repeat (300) begin
         ahb(0, `SVTB_LEVEL_OFS, 0);
         check("tready vs level", tr, rd < 32'd30);
         if (tr === 1'b0) tr_low++;
      end
      check("master buffering", tr_low > 0, 1);
      run_chk = 1;
      master_chk = 1;
      px_seen = 0;
      wait_lock(1, 60000, "master lock");
      wait_frames(3);
      check("master pixels", px_seen > 0, 1);
      run_chk = 0;
      master_chk = 0;
      short_req <= 1'b1;
      wait_lock(0, 4000, "drop on short line");
      short_req <= 1'b0;
      wait_lock(1, 60000, "relock");
      tally_and_finish();
   end
endmodule
`default_nettype wire
